// file: fscp_core.sv
// Operation
// RL1: suspend instruction sets the suspend flag in status bit 15.
// RL2: resume instruction or power cycle clears the suspend flag.
// RL3: three lock bits default 0, settable one by one, never cleared.
// RL4: a set lock bit makes its security register refuse program and erase.
// RL5: quad enable bit 9; when set, protect and pause pins become data lines.
// RL6: enter four-wire command mode is ignored unless quad enable is set.
// RL7: in four-wire command mode quad enable stays 1 against status writes.
// RL8: two-bit drive select gives 100, 75, 50, 25 percent; 25 is default.
// RL9: pin function bit picks pause (0, default) or active-low hardware reset.
// RL10: pause or reset pin function only acts while quad enable is 0.
// RL11: dummy clocks follow the two-bit select per read type; select resets to 00.
// RL12: reserved status bits accept writes with no effect.
// RL13: block granule levels protect 256KB doubling to 8MB, top or bottom.
// RL14: sector granule levels protect 4KB, 8KB, 16KB, 32KB, top or bottom.
// RL15: inversion bit 14 swaps protected and unprotected parts of the array.
// RL16: program or erase overlapping any protected part is refused.
// RL17: one protected flag decoded from the 24-bit address and protect fields.
`timescale 1ns/1ns
`default_nettype none

module fscp_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic link_cmd_valid,
    input wire logic [7:0] link_cmd_code,
    output logic link_four_wire_mode,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic pe_req,
    input wire logic pe_secure,
    input wire logic [1:0] pe_secure_idx,
    input wire logic [23:0] pe_start_addr,
    input wire logic [23:0] pe_end_addr,
    output logic pe_grant,
    output logic pe_deny,
    input wire logic [23:0] chk_addr,
    output logic addr_protected,
    input wire logic protect_pin_n,
    input wire logic pause_pin_n,
    output logic protect_pin_active,
    output logic pause_active,
    output logic hw_reset_active,
    output logic quad_lines_enabled,
    output logic four_wire_command_mode,
    output logic suspend_flag,
    output logic [1:0] drive_sel,
    output logic [3:0] dummy_fast,
    output logic [3:0] dummy_dual_io,
    output logic [3:0] dummy_quad_io
);

    // link side state: the last instruction code and a toggle per instruction
    typedef struct packed {
        logic [7:0] code;
        logic tog;
    } fscp_link_t;

    // state of the register clock domain
    typedef struct packed {
        logic [2:0] protect_level;
        logic bottom_select;
        logic sector_granule;
        logic quad_enable_bit;
        logic secure_lock_a;
        logic secure_lock_b;
        logic secure_lock_c;
        logic protect_invert;
        logic suspend_flag;
        logic four_wire_command_mode;
        logic [1:0] drive_sel;
        logic pin_func;
        logic [1:0] dummy_sel;
        logic tog_seen;
        logic [23:0] probe_addr;
        logic [31:0] rdata;
        logic pe_grant;
        logic pe_deny;
        logic addr_protected;
        logic protect_pin_active;
        logic pause_active;
        logic hw_reset_active;
        logic [3:0] dummy_dual_io;
        logic [3:0] dummy_quad_io;
    } fscp_state_t;

    fscp_link_t l;
    fscp_link_t next_l;
    fscp_state_t s;
    fscp_state_t next_s;

    logic tog_sync;
    logic qpi_link_sync;
    logic [1:0] pins_sync;
    logic cmd_evt;
    logic [24:0] reg_lo;
    logic [24:0] reg_hi;
    logic reg_none;
    logic reg_all;
    logic chk_hit;
    logic probe_hit;
    logic pe_overlap;
    logic pe_locked;
    logic [15:0] status_word;
    logic [31:0] config_word;

    // link domain: hold the instruction code and flip the toggle
    always_comb begin
        next_l = l;
        if (link_cmd_valid) begin
            next_l.code = link_cmd_code;
            next_l.tog = ~l.tog;
        end
    end

    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // instruction toggle into the register domain
    fscp_sync #(.W(1)) u_sync_tog (
        .clk(clk),
        .resetn(resetn),
        .d(l.tog),
        .q(tog_sync)
    );

    // four-wire mode level back to the link domain
    fscp_sync #(.W(1)) u_sync_qpi (
        .clk(link_clk),
        .resetn(resetn),
        .d(s.four_wire_command_mode),
        .q(qpi_link_sync)
    );

    // shared pins pass two flops, inverted so the reset value reads as released
    fscp_sync #(.W(2)) u_sync_pins (
        .clk(clk),
        .resetn(resetn),
        .d({~protect_pin_n, ~pause_pin_n}),
        .q(pins_sync)
    );

    assign cmd_evt = tog_sync != s.tog_seen;

    // region chosen by granule, bottom select and level
    always_comb begin
        logic [24:0] size;
        size = '0;
        reg_none = s.protect_level == fscp_pkg::LEVEL_NONE;
        reg_all = s.protect_level == fscp_pkg::LEVEL_ALL;
        if (!s.sector_granule) begin
            // 256KB doubling per level up to 8MB [RL13]
            size = fscp_pkg::BLOCK_REGION_MIN << (s.protect_level - 3'h1);
        end else begin
            // 4KB, 8KB, 16KB, then 32KB for 10x and 110 [RL14]
            case (s.protect_level)
                3'h1: size = fscp_pkg::SECTOR_4K;
                3'h2: size = fscp_pkg::SECTOR_8K;
                3'h3: size = fscp_pkg::SECTOR_16K;
                default: size = fscp_pkg::SECTOR_32K;
            endcase
        end
        if (reg_all) begin
            size = fscp_pkg::ARRAY_SIZE;
        end
        // top end unless bottom select is set [RL13] [RL14]
        if (s.bottom_select) begin
            reg_lo = '0;
            reg_hi = size - 25'h1;
        end else begin
            reg_lo = fscp_pkg::ARRAY_SIZE - size;
            reg_hi = fscp_pkg::ARRAY_SIZE - 25'h1;
        end
    end

    // single protected flag per address, inverted by the invert bit [RL17] [RL15]
    function automatic logic addr_in_prot(input logic [23:0] a, input logic [24:0] lo,
                                          input logic [24:0] hi, input logic none,
                                          input logic inv);
        logic in_region;
        in_region = !none && ({1'b0, a} >= lo) && ({1'b0, a} <= hi);
        return in_region ^ inv;
    endfunction

    assign chk_hit = addr_in_prot(chk_addr, reg_lo, reg_hi, reg_none, s.protect_invert);
    assign probe_hit = addr_in_prot(s.probe_addr, reg_lo, reg_hi, reg_none, s.protect_invert);

    // range overlap with the protected part, or with its complement [RL16] [RL15]
    always_comb begin
        logic hits_region;
        logic leaves_region;
        hits_region = !reg_none && ({1'b0, pe_start_addr} <= reg_hi)
                      && ({1'b0, pe_end_addr} >= reg_lo);
        leaves_region = reg_none || ({1'b0, pe_start_addr} < reg_lo)
                        || ({1'b0, pe_end_addr} > reg_hi);
        pe_overlap = s.protect_invert ? leaves_region : hits_region;
    end

    // lock bit of the addressed security register [RL4]
    always_comb begin
        case (pe_secure_idx)
            2'h1: pe_locked = s.secure_lock_a;
            2'h2: pe_locked = s.secure_lock_b;
            2'h3: pe_locked = s.secure_lock_c;
            default: pe_locked = 1'b1;
        endcase
    end

    // status read word; reserved and unbuilt bits read as zero [RL12]
    always_comb begin
        status_word = '0;
        status_word[fscp_pkg::POS_SUSPEND] = s.suspend_flag;
        status_word[fscp_pkg::POS_INVERT] = s.protect_invert;
        status_word[fscp_pkg::POS_LOCK_C] = s.secure_lock_c;
        status_word[fscp_pkg::POS_LOCK_B] = s.secure_lock_b;
        status_word[fscp_pkg::POS_LOCK_A] = s.secure_lock_a;
        status_word[fscp_pkg::POS_QUAD] = s.quad_enable_bit;
        status_word[fscp_pkg::POS_GRANULE] = s.sector_granule;
        status_word[fscp_pkg::POS_BOTTOM] = s.bottom_select;
        status_word[fscp_pkg::POS_LEVEL +: 3] = s.protect_level;
        config_word = '0;
        config_word[fscp_pkg::POS_DUMMY_SEL +: 2] = s.dummy_sel;
        config_word[fscp_pkg::POS_PIN_FUNC] = s.pin_func;
        config_word[fscp_pkg::POS_DRIVE +: 2] = s.drive_sel;
    end

    // register domain next state
    always_comb begin
        next_s = s;
        next_s.tog_seen = tog_sync;
        next_s.pe_grant = 1'b0;
        next_s.pe_deny = 1'b0;
        next_s.rdata = '0;

        // software status and config writes
        if (reg_write) begin
            case (reg_addr)
                fscp_pkg::ADDR_STATUS: begin
                    next_s.protect_level = reg_wdata[fscp_pkg::POS_LEVEL +: 3];
                    next_s.bottom_select = reg_wdata[fscp_pkg::POS_BOTTOM];
                    next_s.sector_granule = reg_wdata[fscp_pkg::POS_GRANULE];
                    next_s.protect_invert = reg_wdata[fscp_pkg::POS_INVERT];
                    // quad enable cannot drop while in four-wire mode [RL7]
                    next_s.quad_enable_bit = s.four_wire_command_mode
                                             | reg_wdata[fscp_pkg::POS_QUAD];
                    // lock bits only ever go to 1 [RL3]
                    next_s.secure_lock_a = s.secure_lock_a | reg_wdata[fscp_pkg::POS_LOCK_A];
                    next_s.secure_lock_b = s.secure_lock_b | reg_wdata[fscp_pkg::POS_LOCK_B];
                    next_s.secure_lock_c = s.secure_lock_c | reg_wdata[fscp_pkg::POS_LOCK_C];
                end
                fscp_pkg::ADDR_CONFIG: begin
                    next_s.dummy_sel = reg_wdata[fscp_pkg::POS_DUMMY_SEL +: 2];
                    next_s.pin_func = reg_wdata[fscp_pkg::POS_PIN_FUNC];
                    next_s.drive_sel = reg_wdata[fscp_pkg::POS_DRIVE +: 2]; // [RL8]
                end
                fscp_pkg::ADDR_PROBE: begin
                    next_s.probe_addr = reg_wdata[23:0];
                end
                default: begin
                end
            endcase
        end

        // instructions from the link
        if (cmd_evt) begin
            case (l.code)
                fscp_pkg::OP_SUSPEND: next_s.suspend_flag = 1'b1; // [RL1]
                fscp_pkg::OP_RESUME: next_s.suspend_flag = 1'b0; // [RL2]
                fscp_pkg::OP_ENTER_QPI: begin
                    // ignored unless quad enable is already set [RL6]
                    if (s.quad_enable_bit) begin
                        next_s.four_wire_command_mode = 1'b1;
                        next_s.quad_enable_bit = 1'b1; // a same-cycle write cannot drop it [RL7]
                    end
                end
                fscp_pkg::OP_EXIT_QPI: next_s.four_wire_command_mode = 1'b0;
                default: begin
                end
            endcase
        end

        // register reads, data in the next cycle
        if (reg_read) begin
            case (reg_addr)
                fscp_pkg::ADDR_STATUS: next_s.rdata = {16'h0000, status_word};
                fscp_pkg::ADDR_CONFIG: next_s.rdata = config_word;
                fscp_pkg::ADDR_DUMMY: next_s.rdata = {20'h00000, s.dummy_quad_io,
                                                      s.dummy_dual_io, fscp_pkg::DUMMY_8};
                fscp_pkg::ADDR_PROBE: next_s.rdata = {7'h00, probe_hit, s.probe_addr};
                default: next_s.rdata = '0;
            endcase
        end

        // program and erase check: locked security register or protected overlap
        if (pe_req) begin
            if (pe_secure ? pe_locked : pe_overlap) begin // [RL4] [RL16]
                next_s.pe_deny = 1'b1;
            end else begin
                next_s.pe_grant = 1'b1;
            end
        end

        next_s.addr_protected = chk_hit; // [RL17]

        // shared pin roles only while quad enable is 0 [RL5] [RL9] [RL10]
        next_s.protect_pin_active = !s.quad_enable_bit && pins_sync[1];
        next_s.pause_active = !s.quad_enable_bit && !s.pin_func && pins_sync[0];
        next_s.hw_reset_active = !s.quad_enable_bit && s.pin_func && pins_sync[0];

        // dummy clocks per read type [RL11]
        next_s.dummy_dual_io = s.dummy_sel[0] ? fscp_pkg::DUMMY_8 : fscp_pkg::DUMMY_4;
        case (s.dummy_sel)
            2'h0: next_s.dummy_quad_io = fscp_pkg::DUMMY_6;
            2'h1: next_s.dummy_quad_io = fscp_pkg::DUMMY_4;
            2'h2: next_s.dummy_quad_io = fscp_pkg::DUMMY_8;
            default: next_s.dummy_quad_io = fscp_pkg::DUMMY_10;
        endcase
    end

    // power cycle restores defaults and clears suspend [RL2] [RL3] [RL11]
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.protect_level <= fscp_pkg::RST_LEVEL;
            s.bottom_select <= fscp_pkg::RST_BOTTOM;
            s.sector_granule <= fscp_pkg::RST_GRANULE;
            s.quad_enable_bit <= fscp_pkg::RST_QUAD;
            {s.secure_lock_c, s.secure_lock_b, s.secure_lock_a} <= fscp_pkg::RST_LOCKS;
            s.protect_invert <= fscp_pkg::RST_INVERT;
            s.drive_sel <= fscp_pkg::RST_DRIVE;
            s.pin_func <= fscp_pkg::RST_PIN_FUNC;
            s.dummy_sel <= fscp_pkg::RST_DUMMY_SEL;
            s.dummy_dual_io <= fscp_pkg::DUMMY_4;
            s.dummy_quad_io <= fscp_pkg::DUMMY_6;
        end else begin
            s <= next_s;
        end
    end

    // outputs from flops, except dummy_fast which is the constant DUMMY_8
    assign reg_rdata = s.rdata;
    assign pe_grant = s.pe_grant;
    assign pe_deny = s.pe_deny;
    assign addr_protected = s.addr_protected;
    assign protect_pin_active = s.protect_pin_active;
    assign pause_active = s.pause_active;
    assign hw_reset_active = s.hw_reset_active;
    assign quad_lines_enabled = s.quad_enable_bit; // [RL5]
    assign four_wire_command_mode = s.four_wire_command_mode;
    assign suspend_flag = s.suspend_flag;
    assign drive_sel = s.drive_sel;
    assign dummy_fast = fscp_pkg::DUMMY_8;
    assign dummy_dual_io = s.dummy_dual_io;
    assign dummy_quad_io = s.dummy_quad_io;
    assign link_four_wire_mode = qpi_link_sync;

endmodule

`default_nettype wire

// file: fscp_pkg.sv
package fscp_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_DUMMY = 4'h2;
    localparam logic [3:0] ADDR_PROBE = 4'h3;

    // status word bit positions
    localparam int POS_LEVEL = 2;
    localparam int POS_BOTTOM = 5;
    localparam int POS_GRANULE = 6;
    localparam int POS_QUAD = 9;
    localparam int POS_LOCK_A = 11;
    localparam int POS_LOCK_B = 12;
    localparam int POS_LOCK_C = 13;
    localparam int POS_INVERT = 14;
    localparam int POS_SUSPEND = 15;

    // config word bit positions
    localparam int POS_DUMMY_SEL = 0;
    localparam int POS_PIN_FUNC = 2;
    localparam int POS_DRIVE = 3;

    // values after power-up
    localparam logic [2:0] RST_LEVEL = 3'h0;
    localparam logic RST_BOTTOM = 1'b0;
    localparam logic RST_GRANULE = 1'b0;
    localparam logic RST_QUAD = 1'b0;
    localparam logic [2:0] RST_LOCKS = 3'h0;
    localparam logic RST_INVERT = 1'b0;
    localparam logic [1:0] RST_DRIVE = 2'h3;
    localparam logic RST_PIN_FUNC = 1'b0;
    localparam logic [1:0] RST_DUMMY_SEL = 2'h0;

    // instruction codes seen from the link
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_ENTER_QPI = 8'h38;
    localparam logic [7:0] OP_EXIT_QPI = 8'hff;

    // dummy clock counts
    localparam logic [3:0] DUMMY_4 = 4'h4;
    localparam logic [3:0] DUMMY_6 = 4'h6;
    localparam logic [3:0] DUMMY_8 = 4'h8;
    localparam logic [3:0] DUMMY_10 = 4'ha;

    // protection region sizes in bytes
    localparam logic [24:0] ARRAY_SIZE = 25'h1000000;
    localparam logic [24:0] BLOCK_REGION_MIN = 25'h0040000;
    localparam logic [24:0] SECTOR_4K = 25'h0001000;
    localparam logic [24:0] SECTOR_8K = 25'h0002000;
    localparam logic [24:0] SECTOR_16K = 25'h0004000;
    localparam logic [24:0] SECTOR_32K = 25'h0008000;

    // protection levels with a fixed meaning
    localparam logic [2:0] LEVEL_NONE = 3'h0;
    localparam logic [2:0] LEVEL_ALL = 3'h7;

endpackage

// file: fscp_sync.sv
`timescale 1ns/1ns
`default_nettype none

module fscp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } fscp_sync_t;

    fscp_sync_t s;
    fscp_sync_t next_s;

    // two stage capture; only the second stage is seen outside
    always_comb begin
        next_s = s;
        next_s.meta = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stable;

endmodule

`default_nettype wire

// file: fscp_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fscp_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic pe_req,
    input wire logic pe_grant,
    input wire logic pe_deny,
    input wire logic quad_lines_enabled,
    input wire logic four_wire_command_mode,
    input wire logic protect_pin_active,
    input wire logic pause_active,
    input wire logic hw_reset_active,
    input wire logic [1:0] drive_sel,
    input wire logic [3:0] dummy_fast
);
    // every check runs on the register clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_pe_one_answer: assert property (pe_req |=> pe_grant != pe_deny)
        else $error("program check gave no single answer");
    a_pe_no_stray: assert property (!pe_req |=> !pe_grant && !pe_deny)
        else $error("program check answer without request");
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_mode_keeps_quad: assert property (four_wire_command_mode |-> quad_lines_enabled)
        else $error("quad enable low in four-wire mode");
    a_entry_needs_quad: assert property ($rose(four_wire_command_mode) |->
        $past(quad_lines_enabled))
        else $error("four-wire mode entered without quad enable");
    a_quad_mutes_pins: assert property (quad_lines_enabled && $past(quad_lines_enabled, 2)
        |-> !protect_pin_active && !pause_active && !hw_reset_active)
        else $error("pin function active with quad enable set");
    a_pin_role_excl: assert property (!(pause_active && hw_reset_active))
        else $error("pause and reset roles both active");
    a_fast_dummy: assert property (dummy_fast == fscp_pkg::DUMMY_8)
        else $error("fast read dummy count not eight");
    a_drive_default: assert property ($rose(resetn) |-> drive_sel == 2'h3)
        else $error("drive select not at default after reset");
endmodule
bind fscp_core fscp_sva u_sva (
    .clk(clk), .resetn(resetn), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pe_req(pe_req), .pe_grant(pe_grant), .pe_deny(pe_deny),
    .quad_lines_enabled(quad_lines_enabled), .four_wire_command_mode(four_wire_command_mode),
    .protect_pin_active(protect_pin_active), .pause_active(pause_active),
    .hw_reset_active(hw_reset_active), .drive_sel(drive_sel), .dummy_fast(dummy_fast)
);
`default_nettype wire

// file: fscp_host.sv
`timescale 1ns/1ns
`default_nettype none
module fscp_host (
    input wire logic link_clk,
    output logic link_cmd_valid,
    output logic [7:0] link_cmd_code
);
    // idle link: no instruction pending
    initial begin
        link_cmd_valid = 1'b0;
        link_cmd_code = 8'h00;
    end
    // one executed instruction per call; the idle code is inverted so it never lingers
    task automatic send(input logic [7:0] code);
        @(posedge link_clk);
        link_cmd_valid <= 1'b1;
        link_cmd_code <= code;
        @(posedge link_clk);
        link_cmd_valid <= 1'b0;
        link_cmd_code <= ~code;
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("FAIL %0t value mismatch got %h exp %h", $time, g, e); end end
module testbench;
    logic clk = 1'b0, link_clk = 1'b0, resetn = 1'b0;
    logic link_cmd_valid, link_four_wire_mode;
    logic [7:0] link_cmd_code;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic reg_write = 1'b0, reg_read = 1'b0, pe_req = 1'b0, pe_secure = 1'b0;
    logic [1:0] pe_secure_idx = 2'h0, drive_sel;
    logic [23:0] pe_start_addr = 24'h0, pe_end_addr = 24'h0, chk_addr = 24'h0, s, e;
    logic pe_grant, pe_deny, addr_protected, protect_pin_n = 1'b1, pause_pin_n = 1'b1;
    logic protect_pin_active, pause_active, hw_reset_active, quad_lines_enabled;
    logic four_wire_command_mode, suspend_flag, prev_read = 1'b0;
    logic [3:0] dummy_fast, dummy_dual_io, dummy_quad_io;
    logic [3:0] qd [4] = '{4'h6, 4'h4, 4'h8, 4'ha};
    logic [31:0] rq [$];
    logic pq [$];
    logic [31:0] rng = 32'd65078, r;
    logic [2:0] lvl = 3'h0, locks = 3'h0;
    logic sec = 1'b0, bot = 1'b0, inv = 1'b0;
    int failures = 0, cmp_count = 0, k;

    // register clock and an unrelated link clock
    always #50 clk = ~clk;
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end

    fscp_core u_fscp_core (.clk, .resetn, .link_clk, .link_cmd_valid, .link_cmd_code,
        .link_four_wire_mode, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .pe_req, .pe_secure, .pe_secure_idx, .pe_start_addr, .pe_end_addr, .pe_grant,
        .pe_deny, .chk_addr, .addr_protected, .protect_pin_n, .pause_pin_n,
        .protect_pin_active, .pause_active, .hw_reset_active, .quad_lines_enabled,
        .four_wire_command_mode, .suspend_flag, .drive_sel, .dummy_fast, .dummy_dual_io,
        .dummy_quad_io);
    fscp_host u_fscp_host (.link_clk, .link_cmd_valid, .link_cmd_code);

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // expected protection of one address from the current fields
    function automatic logic prot(input logic [23:0] a);
        logic [24:0] sz;
        if (lvl == 3'h0) sz = 25'h0;
        else if (lvl == 3'h7) sz = fscp_pkg::ARRAY_SIZE;
        else if (!sec) sz = fscp_pkg::BLOCK_REGION_MIN << (lvl - 1);
        else if (lvl < 3'h4) sz = fscp_pkg::SECTOR_4K << (lvl - 1);
        else sz = fscp_pkg::SECTOR_32K;
        return inv ^ (bot ? {1'b0, a} < sz : {1'b0, a} >= fscp_pkg::ARRAY_SIZE - sz);
    endfunction

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        rq.push_back(x);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic setprot(input logic c, input logic b, input logic [2:0] l, input logic i);
        sec = c;
        bot = b;
        lvl = l;
        inv = i;
        wr(fscp_pkg::ADDR_STATUS, {17'h0, i, locks, 4'h0, c, b, l, 2'h0});
    endtask

    task automatic pe(input logic [23:0] a, input logic [23:0] z, input logic c,
                      input logic [1:0] ix, input logic dn);
        pq.push_back(dn);
        pe_start_addr <= a;
        pe_end_addr <= z;
        chk_addr <= a;
        pe_secure <= c;
        pe_secure_idx <= ix;
        pe_req <= 1'b1;
        @(posedge clk);
        pe_req <= 1'b0;
        @(negedge clk);
        `CHK(addr_protected, prot(a))
        @(posedge clk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // results are matched against the oldest expectation
    always @(negedge clk) begin
        if (prev_read) `CHK(reg_rdata, rq.pop_front())
        prev_read = reg_read;
        if (pe_grant === 1'b1 || pe_deny === 1'b1) `CHK(pe_deny, pq.pop_front())
    end

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(fscp_pkg::ADDR_STATUS, 32'h0);
        rd(fscp_pkg::ADDR_CONFIG, 32'h18);
        rd(fscp_pkg::ADDR_DUMMY, 32'h648);
        rd(4'h9, 32'h0);
        $display("test reset values done");
        // lock bits one at a time, reserved and suspend bits written high
        for (int i = 0; i < 3; i++) begin
            wr(fscp_pkg::ADDR_STATUS, 32'h8583 | (32'h800 << i));
            locks[i] = 1'b1;
            rd(fscp_pkg::ADDR_STATUS, {18'h0, locks, 11'h0});
            wr(fscp_pkg::ADDR_STATUS, 32'h0);
            for (int j = 0; j < 4; j++)
                pe(24'h0, 24'h0, 1'b1, j[1:0], j == 0 || locks[j - 1]);
        end
        $display("test lock bits done");
        // random fields against boundary and random ranges
        repeat (200) begin
            r = rnd();
            setprot(r[0], r[1], r[4:2], r[5]);
            k = 12 + r[9:6] % 12;
            s = (24'h1 << k) - r[10];
            if (r[11]) s = ~s;
            if (r[12]) s = r[31:8];
            e = s | 24'(rnd() >> (8 + 2 * r[15:13]));
            pe(s, e, 1'b0, 2'h0, prot(s) | prot(e));
        end
        setprot(1'b0, 1'b0, 3'h0, 1'b0);
        $display("test protection done");
        u_fscp_host.send(fscp_pkg::OP_SUSPEND);
        repeat (12) @(posedge clk);
        `CHK(suspend_flag, 1'b1)
        wr(fscp_pkg::ADDR_STATUS, {18'h0, locks, 11'h0});
        rd(fscp_pkg::ADDR_STATUS, {16'h0, 1'b1, 1'b0, locks, 11'h0});
        u_fscp_host.send(fscp_pkg::OP_RESUME);
        repeat (12) @(posedge clk);
        rd(fscp_pkg::ADDR_STATUS, {18'h0, locks, 11'h0});
        $display("test suspend done");
        // pin roles, quad enable and four-wire mode
        protect_pin_n <= 1'b0;
        pause_pin_n <= 1'b0;
        u_fscp_host.send(fscp_pkg::OP_ENTER_QPI);
        repeat (12) @(posedge clk);
        `CHK(four_wire_command_mode, 1'b0)
        `CHK({protect_pin_active, pause_active, hw_reset_active}, 3'b110)
        wr(fscp_pkg::ADDR_CONFIG, 32'h1c);
        repeat (4) @(posedge clk);
        `CHK({protect_pin_active, pause_active, hw_reset_active}, 3'b101)
        wr(fscp_pkg::ADDR_STATUS, {18'h0, locks, 2'h1, 9'h0});
        repeat (4) @(posedge clk);
        `CHK({protect_pin_active, pause_active, hw_reset_active}, 3'b000)
        `CHK(quad_lines_enabled, 1'b1)
        u_fscp_host.send(fscp_pkg::OP_ENTER_QPI);
        repeat (12) @(posedge clk);
        `CHK({four_wire_command_mode, link_four_wire_mode}, 2'b11)
        wr(fscp_pkg::ADDR_STATUS, {18'h0, locks, 11'h0});
        rd(fscp_pkg::ADDR_STATUS, {18'h0, locks, 2'h1, 9'h0});
        u_fscp_host.send(fscp_pkg::OP_EXIT_QPI);
        repeat (12) @(posedge clk);
        wr(fscp_pkg::ADDR_STATUS, {18'h0, locks, 11'h0});
        rd(fscp_pkg::ADDR_STATUS, {18'h0, locks, 11'h0});
        repeat (4) @(posedge clk);
        `CHK({protect_pin_active, pause_active, hw_reset_active}, 3'b101)
        $display("test quad and pins done");
        // every drive and dummy select
        for (int i = 0; i < 4; i++) begin
            wr(fscp_pkg::ADDR_CONFIG, {27'h0, i[1:0], 1'b0, i[1:0]});
            rd(fscp_pkg::ADDR_DUMMY, {20'h0, qd[i], i[0] ? 4'h8 : 4'h4, 4'h8});
            `CHK({dummy_dual_io, dummy_quad_io}, {i[0] ? 4'h8 : 4'h4, qd[i]})
            `CHK(drive_sel, i[1:0])
        end
        $display("test drive and dummy done");
        `CHK(rq.size() + pq.size(), 0)
        complete_run();
    end
endmodule
`default_nettype wire
